//--- logic/eac_device.sv
`default_nettype none
module eac_device
	import eac_pkg::*;
#(
	parameter int ATOMIC_CYCLES = ATOMIC_CYC,
	parameter int SPLIT_CYCLES  = SPLIT_CYC
)(
	input  wire logic   sys_clk,
	input  wire logic   rst_b,
	input  wire logic   global_irq_enable,
	eac_if.device       bus
);
	import eac_pkg::*;

	logic [7:0]           mem [0:MEM_BYTES-1];
	logic [ADDR_BITS-1:0] byte_address_register;
	logic [7:0]           nv_data_byte;
	eac_mode_t            mode_field;
	logic                 ready_irq_enable;
	logic                 master_enable;
	logic [2:0]           master_count;
	logic                 program_strobe;
	logic [22:0]          prog_count;
	logic [2:0]           stall_count;
	logic [7:0]           rdata;
	logic                 wr_ctl;
	logic                 prog_go;
	logic                 read_go;
	logic [22:0]          prog_end;

	assign wr_ctl  = bus.io_wr && (bus.io_addr == OFS_CONTROL);
	assign prog_go = wr_ctl && bus.io_wdata[BIT_PROG] && master_enable && !program_strobe; // [R13]
	assign read_go = wr_ctl && bus.io_wdata[BIT_READ] && !program_strobe; // [R18]
	assign prog_end = (mode_field == EAC_MODE_ATOMIC) ? 23'(ATOMIC_CYCLES - 1)
		: 23'(SPLIT_CYCLES - 1); // [R7] [R23]

	////////////////////////////////////////////////////////////////////////////
	// Address and data registers; the address has no reset value.
	always_ff @(posedge sys_clk)
	begin
		if (bus.io_wr && !program_strobe) // [R18] [R3]
		begin
			if (bus.io_addr == OFS_ADDR_LOW)
				byte_address_register[7:0] <= bus.io_wdata; // [R4]
			if (bus.io_addr == OFS_ADDR_HIGH)
				byte_address_register[8] <= bus.io_wdata[0]; // [R2]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			nv_data_byte <= 8'h00;
		else if (read_go)
			nv_data_byte <= mem[byte_address_register]; // [R16] [R5]
		else if (bus.io_wr && bus.io_addr == OFS_DATA)
			nv_data_byte <= bus.io_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory array; programming effect is applied when the timer ends.
	always_ff @(posedge sys_clk)
	begin
		if (program_strobe && prog_count == prog_end)
		begin
			unique case (mode_field)
				EAC_MODE_ATOMIC:   mem[byte_address_register] <= nv_data_byte; // [R7]
				EAC_MODE_ERASE:    mem[byte_address_register] <= ERASED_BYTE;
				// Programming only clears bits, so an unerased byte ends up mixed.
				EAC_MODE_WRITE:    mem[byte_address_register] <=
					mem[byte_address_register] & nv_data_byte; // [R20]
				EAC_MODE_RESERVED: ; // [R22]
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control bits. Programming state is kept across reset so it completes.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			ready_irq_enable <= 1'b0;
		else if (wr_ctl)
			ready_irq_enable <= bus.io_wdata[BIT_IRQ_EN]; // [R10]
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b && !program_strobe)
			mode_field <= EAC_MODE_ATOMIC; // [R9]
		else if (wr_ctl && !program_strobe)
			mode_field <= eac_mode_t'(bus.io_wdata[BIT_MODE_HI:BIT_MODE_LO]); // [R8]
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			master_enable <= 1'b0;
			master_count  <= 3'h0;
		end
		else if (wr_ctl && bus.io_wdata[BIT_MASTER])
		begin
			master_enable <= 1'b1;
			master_count  <= MASTER_CYCLES - 3'h1;
		end
		else if (master_enable)
		begin
			master_count  <= master_count - 3'h1;
			master_enable <= (master_count != 3'h0); // [R12]
		end
	end

	// Timer runs without reset so a reset does not abort a write.
	always_ff @(posedge sys_clk)
	begin
		if (prog_go)
		begin
			program_strobe <= 1'b1;
			prog_count     <= 23'h0;
		end
		else if (program_strobe)
		begin
			prog_count     <= prog_count + 23'h1; // [R23]
			program_strobe <= (prog_count != prog_end); // [R14] [R21]
		end
		else
		begin
			program_strobe <= 1'b0;
			prog_count     <= 23'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// CPU stall and read-back.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			stall_count <= 3'h0;
		else if (prog_go)
			stall_count <= {1'b0, PROG_STALL}; // [R15]
		else if (read_go)
			stall_count <= READ_STALL; // [R17]
		else if (stall_count != 3'h0)
			stall_count <= stall_count - 3'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= 8'h00;
		else if (bus.io_rd)
		begin
			unique case (bus.io_addr)
				OFS_ADDR_LOW:  rdata <= byte_address_register[7:0];
				OFS_ADDR_HIGH: rdata <= {7'h00, byte_address_register[8]}; // [R1]
				OFS_DATA:      rdata <= nv_data_byte;
				OFS_CONTROL:   rdata <= {2'b00, mode_field, ready_irq_enable,
					master_enable, program_strobe, 1'b0}; // [R6]
				default:       rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	assign bus.io_rdata  = rdata;
	assign bus.cpu_halt  = (stall_count != 3'h0);
	assign bus.ready_irq = ready_irq_enable && global_irq_enable && !program_strobe; // [R11] [R10]
endmodule
`default_nettype wire

//--- logic/eac_pkg.sv
// Functional notes
// [R1] Address-high bits 7:1 read zero
// [R2] Address top bit only in largest variant
// [R3] Address undefined at reset; load first
// [R4] Linear byte addressing, unused bits read zero
// [R5] Data byte: program source, read result
// [R6] Control bits 7:6 read zero
// [R7] Mode selects erase+write, erase, write
// [R8] Mode writes ignored while programming
// [R9] Mode clears on reset unless busy
// [R10] Ready interrupt gated by enable, global flag
// [R11] Ready interrupt is a level while idle
// [R12] Master enable self-clears after four cycles
// [R13] Program strobe needs master enable set
// [R14] Program strobe held until time elapses
// [R15] Accepted program strobe stalls CPU two cycles
// [R16] Read strobe fetches byte immediately
// [R17] Read strobe stalls CPU four cycles
// [R18] Busy blocks reads and address writes
// [R19] Software polls program strobe before reading
// [R20] Write-only on unerased byte gives undefined data
// [R21] Programming completes across reset
// [R22] Reserved mode clears without touching memory
// [R23] Programming timed by terminal count
`default_nettype none
package eac_pkg;
	localparam int          MEM_BYTES     = 512;
	localparam int          ADDR_BITS     = 9;
	localparam logic [5:0]  OFS_ADDR_LOW  = 6'h1e;
	localparam logic [5:0]  OFS_ADDR_HIGH = 6'h1f;
	localparam logic [5:0]  OFS_DATA      = 6'h1d;
	localparam logic [5:0]  OFS_CONTROL   = 6'h1c;
	localparam int          BIT_READ      = 0;
	localparam int          BIT_PROG      = 1;
	localparam int          BIT_MASTER    = 2;
	localparam int          BIT_IRQ_EN    = 3;
	localparam int          BIT_MODE_LO   = 4;
	localparam int          BIT_MODE_HI   = 5;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [2:0]  MASTER_CYCLES = 3'h4;
	localparam logic [1:0]  PROG_STALL    = 2'h2;
	localparam logic [2:0]  READ_STALL    = 3'h4;
	localparam int          CLK_HZ        = 50000000;
	localparam int          T_ATOMIC_US   = 3400;
	localparam int          T_SPLIT_US    = 1800;
	localparam int          ATOMIC_CYC    = T_ATOMIC_US * (CLK_HZ / 1000000);
	localparam int          SPLIT_CYC     = T_SPLIT_US * (CLK_HZ / 1000000);
	typedef enum logic [1:0] {
		EAC_MODE_ATOMIC  = 2'h0,
		EAC_MODE_ERASE   = 2'h1,
		EAC_MODE_WRITE   = 2'h2,
		EAC_MODE_RESERVED = 2'h3
	} eac_mode_t;
endpackage
`default_nettype wire

//--- logic/eac_if.sv
`default_nettype none
interface eac_if;
	logic       io_wr;
	logic       io_rd;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       cpu_halt;
	logic       ready_irq;
	modport device (
		input  io_wr, io_rd, io_addr, io_wdata,
		output io_rdata, cpu_halt, ready_irq
	);
	modport core (
		output io_wr, io_rd, io_addr, io_wdata,
		input  io_rdata, cpu_halt, ready_irq
	);
endinterface
`default_nettype wire

//--- logic/eac_core.sv
`default_nettype none
module eac_core
	import eac_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [5:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	output logic      [7:0]  cmd_rdata,
	output logic             cmd_halted,
	output logic             irq_seen,
	eac_if.core              bus
);
	import eac_pkg::*;

	// Software places orders on the command port; the core forwards them one cycle later,
	// writing zero to reserved control bits and passing read data through unmasked.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus.io_wr    <= 1'b0;
			bus.io_rd    <= 1'b0;
			bus.io_addr  <= 6'h00;
			bus.io_wdata <= 8'h00;
		end
		else
		begin
			bus.io_wr    <= cmd_wr;
			bus.io_rd    <= cmd_rd;
			bus.io_addr  <= cmd_addr;
			bus.io_wdata <= (cmd_addr == OFS_CONTROL) ? {2'b00, cmd_wdata[5:0]} : cmd_wdata; // [R6]
		end
	end

	assign cmd_rdata  = bus.io_rdata;
	assign cmd_halted = bus.cpu_halt;
	assign irq_seen   = bus.ready_irq;
endmodule
`default_nettype wire

//--- verification/eac_checker.sv
`default_nettype none
module eac_checker
	import eac_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic       global_irq_enable,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       cpu_halt,
	input wire logic       ready_irq
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	wire ctl_wr = io_wr && io_addr == OFS_CONTROL;
	wire ctl_rd = io_rd && io_addr == OFS_CONTROL;
	wire hi_rd  = io_rd && io_addr == OFS_ADDR_HIGH;
	wire arm    = ctl_wr && io_wdata[2] && !io_wdata[1] && ready_irq;
	property p_rd_idle; !$past(io_rd) |-> io_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_ctl; $past(ctl_rd) |-> io_rdata[7:6] == 2'h0 && !io_rdata[0]; endproperty
	a_ctl: assert property (p_ctl) else $error("control spare bits set");
	property p_hi; $past(hi_rd) |-> io_rdata[7:1] == 7'h00; endproperty
	a_hi: assert property (p_hi) else $error("address high spare bits set");
	property p_gate; !global_irq_enable |-> !ready_irq; endproperty
	a_gate: assert property (p_gate) else $error("ready request not gated");
	// The core flag may drop in the same cycle; only a steady flag keeps the level.
	property p_lvl;
		ready_irq && !io_wr && global_irq_enable ##1 global_irq_enable |-> ready_irq;
	endproperty
	a_lvl: assert property (p_lvl) else $error("ready request dropped");
	property p_len;
		$rose(cpu_halt) |-> cpu_halt[*2] ##1 (!cpu_halt or (cpu_halt[*2] ##1 !cpu_halt));
	endproperty
	a_len: assert property (p_len) else $error("stall length wrong");
	property p_rd_st;
		ctl_wr && io_wdata[0] && !io_wdata[1] && ready_irq |=> cpu_halt[*4] ##1 !cpu_halt;
	endproperty
	a_rd_st: assert property (p_rd_st) else $error("read stall wrong");
	property p_go;
		arm ##1 ctl_wr && io_wdata[1] |=> cpu_halt[*2] ##1 !cpu_halt && !ready_irq;
	endproperty
	a_go: assert property (p_go) else $error("program start wrong");
	property p_late; arm ##5 ctl_wr && io_wdata[1] |=> !cpu_halt; endproperty
	a_late: assert property (p_late) else $error("late program accepted");
	c_go: cover property (arm ##1 ctl_wr && io_wdata[1]);
	c_late: cover property (arm ##5 ctl_wr && io_wdata[1]);
	c_rd: cover property (ctl_wr && io_wdata[0] && ready_irq);
endmodule
`default_nettype wire

//--- verification/eeprom_access_control_tb.sv
`default_nettype none
module eeprom_access_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import eac_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       global_irq_enable = 1'b1;
	logic       cmd_wr = 1'b0;
	logic       cmd_rd = 1'b0;
	logic [5:0] cmd_addr = 6'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic [7:0] cmd_rdata;
	logic       cmd_halted;
	logic       irq_seen;
	logic [7:0] v, d, e;
	logic [8:0] a;
	int         bad_count = 0;
	int         cmp_count = 0;
	eac_if bus ();
	always #10 sys_clk = ~sys_clk;
	eac_device #(.ATOMIC_CYCLES(20), .SPLIT_CYCLES(10)) i_eac_device (.sys_clk(sys_clk),
		.rst_b(rst_b), .global_irq_enable(global_irq_enable), .bus(bus));
	eac_core i_eac_core (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
		.cmd_halted(cmd_halted), .irq_seen(irq_seen), .bus(bus));
	eac_checker i_eac_checker (.sys_clk(sys_clk), .rst_b(rst_b),
		.global_irq_enable(global_irq_enable), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
		.io_addr(bus.io_addr), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata),
		.cpu_halt(bus.cpu_halt), .ready_irq(bus.ready_irq));
	task automatic chk(input logic [7:0] x, input logic [7:0] g);
		cmp_count++;
		if (g !== x)
		begin
			bad_count++;
			$display("unexpected at %0t: exp %h got %h", $time, x, g);
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
		cmd_wr <= 1'b1;
		cmd_addr <= ad;
		cmd_wdata <= dt;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		cmd_wr <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [5:0] ad);
		cmd_wr <= 1'b0;
		cmd_rd <= 1'b1;
		cmd_addr <= ad;
		@(posedge sys_clk);
		cmd_rd <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		v = cmd_rdata;
		@(posedge sys_clk);
	endtask
	task automatic seta();
		wr(OFS_ADDR_HIGH, {7'h00, a[8]});
		wr(OFS_ADDR_LOW, a[7:0]);
	endtask
	// Master enable, then program strobe with master still set, as software does it.
	task automatic prog(input logic [1:0] md);
		seta();
		wr(OFS_DATA, d);
		wr(OFS_CONTROL, {2'h0, md, 4'h8});
		wr(OFS_CONTROL, {2'h0, md, 4'hc});
		wr(OFS_CONTROL, {2'h0, md, 4'he});
		idle(4);
	endtask
	task automatic done();
		for (int i = 0; i < 40; i++)
		begin
			rd(OFS_CONTROL);
			if (v[1] === 1'b0)
				return;
		end
		bad_count++;
		complete_run();
	endtask
	task automatic rmem(input logic [1:0] md);
		seta();
		wr(OFS_CONTROL, {2'h0, md, 4'h9});
		idle(2);
		chk(8'h01, {7'h00, cmd_halted});
		idle(6);
		rd(OFS_DATA);
		chk(e, v);
	endtask
	initial
	begin
		void'($urandom(32'hfd34));
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		wr(OFS_CONTROL, 8'h08);
		idle(2);
		for (int j = 0; j < 2; j++)
		begin
			a = 9'($urandom());
			for (int k = 0; k < 4; k++)
			begin
				d = 8'($urandom());
				prog(2'(k));
				done();
				e = (k == 0) ? d : (k == 1) ? 8'hff : (k == 2) ? (e & d) : e;
				rmem(2'(k));
				rd(OFS_CONTROL);
				chk({2'h0, 2'(k), 4'h0}, v & 8'hf1);
			end
			rd(OFS_ADDR_HIGH);
			chk({7'h00, a[8]}, v);
			rd(OFS_ADDR_LOW);
			chk(a[7:0], v);
		end
		wr(OFS_DATA, ~e);
		wr(OFS_CONTROL, 8'h0c);
		idle(4);
		wr(OFS_CONTROL, 8'h0a);
		idle(4);
		rmem(2'h0);
		d = 8'($urandom());
		prog(2'h0);
		wr(OFS_ADDR_LOW, ~a[7:0]);
		wr(OFS_CONTROL, 8'h39);
		idle(2);
		rd(OFS_CONTROL);
		chk(8'h02, v & 8'hf3);
		done();
		rd(OFS_ADDR_LOW);
		chk(a[7:0], v);
		rd(OFS_DATA);
		chk(d, v);
		chk(8'h01, {7'h00, irq_seen});
		global_irq_enable <= 1'b0;
		idle(2);
		chk(8'h00, {7'h00, irq_seen});
		global_irq_enable <= 1'b1;
		prog(2'h1);
		e = 8'hff;
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		idle(1);
		rd(OFS_CONTROL);
		chk(8'h10, v & 8'h30);
		done();
		rmem(2'h1);
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		idle(1);
		rd(OFS_CONTROL);
		chk(8'h00, v & 8'h30);
		complete_run();
	end
endmodule
`default_nettype wire
